// ---- src/baau_core.v ----
// internal data space bit decoder and accumulator arithmetic datapath
//
// How it works
// - bit addresses 00h..7Fh select bit n of ram byte 20h+k for bit address 8k+n.
// - bit addresses 80h and up select bit n of the special register at the address minus n.
// - every bit addressable byte stays byte accessible; a bit write changes one bit only, and one to the accumulator also moves the parity flag.
// - ram bytes 30h..BFh are byte access only and bytes below 20h hold the register banks.
// - an add takes one machine cycle, one byte for register or indirect, two otherwise.
// - add with carry sums accumulator, operand and carry with the add's forms and timing.
// - subtract with borrow takes operand and carry from the accumulator in one cycle.
`timescale 1ns/100ps
`default_nettype none
`include "baau_consts.vh"

module baau_core #(
    parameter RAM_BYTES = 192
) (
    input  wire        clk,
    input  wire        rst,
    input  wire [7:0]  byte_addr,
    input  wire        byte_indirect,
    input  wire        byte_we,
    input  wire [7:0]  byte_wdata,
    output reg  [7:0]  byte_rdata_q,
    input  wire [7:0]  bit_addr,
    input  wire        bit_we,
    input  wire        bit_wdata,
    output reg         bit_rdata_q,
    input  wire        op_start,
    input  wire [3:0]  op_code,
    input  wire [1:0]  op_form,
    input  wire [7:0]  op_operand,
    output wire        op_ready,
    output reg         op_done_q,
    output reg  [7:0]  op_result_q,
    output wire [1:0]  op_length,
    output wire [7:0]  acc_out,
    output wire [7:0]  psw_out,
    output wire [15:0] data_pointer_out
);

    reg  [7:0]  ram_q [0:RAM_BYTES-1];
    reg  [7:0]  sfr_q [0:15];
    reg  [7:0]  acc_q;
    reg  [7:0]  md_q;
    reg  [7:0]  psw_q;
    reg  [15:0] data_pointer_q;
    reg  [2:0]  cnt_q;
    reg  [7:0]  pend_acc_q;
    reg  [7:0]  pend_md_q;
    reg  [7:0]  pend_psw_q;
    reg  [15:0] pend_data_pointer_q;

    reg  [7:0]  new_acc;
    reg  [7:0]  new_md;
    reg  [7:0]  new_psw;
    reg  [15:0] new_data_pointer;
    reg  [7:0]  new_res;
    reg  [2:0]  new_cyc;
    reg  [8:0]  wide;
    reg  [4:0]  nib;
    reg  [15:0] prod;
    reg  [7:0]  bit_byte;
    reg  [7:0]  bit_merged;
    reg  [7:0]  byte_view;
    reg  [7:0]  acc_d;
    reg  [7:0]  md_d;
    reg  [7:0]  psw_d;

    wire        take;
    wire        commit_now;
    wire        commit_late;
    wire        cin;
    wire [7:0]  bit_target;

    integer     i;

    // byte address holding a given bit address
    function [7:0] bit_to_byte;
        input [7:0] ba;
        begin
            if (!ba[7])
                bit_to_byte = `BAAU_BITRAM_BASE + {4'h0, ba[6:3]};
            else
                bit_to_byte = {ba[7:3], 3'b000};
        end
    endfunction

    // true when a direct address names a bit addressable register kept in the array
    function sfr_slot_ok;
        input [7:0] a;
        begin
            sfr_slot_ok = (a[2:0] == 3'b000) && (a != 8'h98) && (a != 8'hC0)
                        && (a != 8'hE8) && (a != 8'hF8);
        end
    endfunction

    // read view of any byte; stored words come in as arguments so that @* sees them change
    function [7:0] read_byte(input [7:0] a, input ind, input [7:0] ram_w, input [7:0] sfr_w,
                             input [7:0] acc, input [7:0] md, input [7:0] program_status_word);
        begin
            if (ind || !a[7])
                read_byte = (a <= `BAAU_RAM_TOP) ? ram_w : 8'h00;
            else if (a == `BAAU_ACC)
                read_byte = acc;
            else if (a == `BAAU_MD_OPERAND)
                read_byte = md;
            else if (a == `BAAU_PSW)
                read_byte = program_status_word;
            else if (sfr_slot_ok(a))
                read_byte = sfr_w;
            else
                read_byte = 8'h00;
        end
    endfunction

    assign cin        = psw_q[`BAAU_PSW_CY];
    assign take       = op_start && op_ready;
    assign op_ready   = (cnt_q == 3'h0);
    assign commit_now = take && (new_cyc == `BAAU_CYC_SHORT);
    assign commit_late = (cnt_q == 3'h1);
    assign bit_target = bit_to_byte(bit_addr);
    // register and indirect forms carry no operand byte
    assign op_length  = ((op_form == `BAAU_FORM_REG) || (op_form == `BAAU_FORM_INDIRECT))
                        ? 2'h1 : 2'h2;
    assign acc_out    = acc_q;
    assign psw_out    = psw_q;
    assign data_pointer_out = data_pointer_q;

    // operation results, worked out from the state at the start edge
    always @* begin
        new_acc  = acc_q;
        new_md   = md_q;
        new_psw  = psw_q;
        new_data_pointer = data_pointer_q;
        new_res  = acc_q;
        new_cyc  = `BAAU_CYC_SHORT;
        wide     = 9'h000;
        nib      = 5'h00;
        prod     = 16'h0000;
        case (op_code)
            `BAAU_OP_ADD, `BAAU_OP_ADD_WITH_CARRY: begin
                // plain add forces the carry in to zero
                wide = {1'b0, acc_q} + {1'b0, op_operand}
                     + {8'h00, (op_code == `BAAU_OP_ADD_WITH_CARRY) & cin};
                nib  = {1'b0, acc_q[3:0]} + {1'b0, op_operand[3:0]}
                     + {4'h0, (op_code == `BAAU_OP_ADD_WITH_CARRY) & cin};
                new_acc = wide[7:0];
                new_psw[`BAAU_PSW_CY] = wide[8];
                new_psw[`BAAU_PSW_AC] = nib[4];
                new_psw[`BAAU_PSW_OV] = (acc_q[7] == op_operand[7]) && (wide[7] != acc_q[7]);
            end
            `BAAU_OP_SUBTRACT_WITH_BORROW: begin
                wide = {1'b0, acc_q} - {1'b0, op_operand} - {8'h00, cin};
                nib  = {1'b0, acc_q[3:0]} - {1'b0, op_operand[3:0]} - {4'h0, cin};
                new_acc = wide[7:0];
                new_psw[`BAAU_PSW_CY] = wide[8];
                new_psw[`BAAU_PSW_AC] = nib[4];
                new_psw[`BAAU_PSW_OV] = (acc_q[7] != op_operand[7]) && (wide[7] != acc_q[7]);
            end
            `BAAU_OP_INC_A: new_acc = acc_q + 8'h01;
            `BAAU_OP_DEC_A: new_acc = acc_q - 8'h01;
            `BAAU_OP_INC_OPND: new_res = op_operand + 8'h01;
            `BAAU_OP_DEC_OPND: new_res = op_operand - 8'h01;
            `BAAU_OP_INC_DATA_POINTER: begin
                new_data_pointer = data_pointer_q + 16'h0001;
                new_cyc  = `BAAU_CYC_DATA_POINTER;
            end
            `BAAU_OP_MUL: begin
                prod    = acc_q * md_q;
                new_acc = prod[7:0];
                new_md  = prod[15:8];
                new_psw[`BAAU_PSW_CY] = 1'b0;
                new_psw[`BAAU_PSW_OV] = (prod[15:8] != 8'h00);
                new_cyc = `BAAU_CYC_MULDIV;
            end
            `BAAU_OP_DIV: begin
                // a zero divisor leaves both operands and flags overflow
                if (md_q != 8'h00) begin
                    new_acc = acc_q / md_q;
                    new_md  = acc_q % md_q;
                end
                new_psw[`BAAU_PSW_CY] = 1'b0;
                new_psw[`BAAU_PSW_OV] = (md_q == 8'h00);
                new_cyc = `BAAU_CYC_MULDIV;
            end
            `BAAU_OP_DA: begin
                wide = {1'b0, acc_q};
                if ((acc_q[3:0] > 4'h9) || psw_q[`BAAU_PSW_AC])
                    wide = wide + 9'h006;
                if ((wide[7:4] > 4'h9) || wide[8] || cin)
                    wide = wide + 9'h060;
                new_acc = wide[7:0];
                new_psw[`BAAU_PSW_CY] = wide[8] | cin;
            end
            default: new_res = acc_q;
        endcase
        if (op_code != `BAAU_OP_INC_OPND && op_code != `BAAU_OP_DEC_OPND)
            new_res = new_acc;
    end

    // bit write: read the whole byte, change one bit, write it back
    always @* begin
        bit_byte   = read_byte(bit_target, 1'b0, ram_q[bit_target], sfr_q[bit_target[6:3]],
                               acc_q, md_q, psw_q);
        bit_merged = bit_byte;
        bit_merged[bit_addr[2:0]] = bit_wdata;
        byte_view  = read_byte(byte_addr, byte_indirect, ram_q[byte_addr],
                               sfr_q[byte_addr[6:3]], acc_q, md_q, psw_q);
    end

    // accumulator, operand and status: arithmetic commit wins over a software write
    always @* begin
        acc_d = acc_q;
        md_d  = md_q;
        psw_d = psw_q;
        if (byte_we && !byte_indirect && byte_addr == `BAAU_ACC)
            acc_d = byte_wdata;
        if (byte_we && !byte_indirect && byte_addr == `BAAU_MD_OPERAND)
            md_d = byte_wdata;
        if (byte_we && !byte_indirect && byte_addr == `BAAU_PSW)
            psw_d = byte_wdata;
        if (bit_we && bit_target == `BAAU_ACC)
            acc_d = bit_merged;
        if (bit_we && bit_target == `BAAU_MD_OPERAND)
            md_d = bit_merged;
        if (bit_we && bit_target == `BAAU_PSW)
            psw_d = bit_merged;
        if (commit_now) begin
            acc_d = new_acc;
            md_d  = new_md;
            psw_d = new_psw;
        end else if (commit_late) begin
            acc_d = pend_acc_q;
            md_d  = pend_md_q;
            psw_d = pend_psw_q;
        end
        // parity always follows the accumulator that will be held
        psw_d[`BAAU_PSW_P] = ^acc_d;
    end

    always @(posedge clk) begin
        if (rst) begin
            acc_q       <= `BAAU_REG_RESET;
            md_q        <= `BAAU_REG_RESET;
            psw_q       <= `BAAU_REG_RESET;
            data_pointer_q      <= `BAAU_DATA_POINTER_RESET;
            cnt_q       <= 3'h0;
            pend_acc_q  <= `BAAU_REG_RESET;
            pend_md_q   <= `BAAU_REG_RESET;
            pend_psw_q  <= `BAAU_REG_RESET;
            pend_data_pointer_q <= `BAAU_DATA_POINTER_RESET;
            op_done_q   <= 1'b0;
            op_result_q <= `BAAU_REG_RESET;
            byte_rdata_q <= `BAAU_REG_RESET;
            bit_rdata_q <= 1'b0;
            for (i = 0; i < 16; i = i + 1)
                sfr_q[i] <= `BAAU_REG_RESET;
        end else begin
            acc_q <= acc_d;
            md_q  <= md_d;
            psw_q <= psw_d;
            byte_rdata_q <= byte_view;
            bit_rdata_q  <= bit_byte[bit_addr[2:0]];
            op_done_q    <= commit_now || commit_late;
            if (take && !commit_now) begin
                // long operations hold their results until the last cycle
                cnt_q       <= new_cyc - 3'h1;
                pend_acc_q  <= new_acc;
                pend_md_q   <= new_md;
                pend_psw_q  <= new_psw;
                pend_data_pointer_q <= new_data_pointer;
            end else if (cnt_q != 3'h0) begin
                cnt_q <= cnt_q - 3'h1;
            end
            if (commit_now)
                op_result_q <= new_res;
            if (commit_late) begin
                data_pointer_q      <= pend_data_pointer_q;
                op_result_q <= pend_acc_q;
            end
            if (byte_we && !byte_indirect && byte_addr[7] && sfr_slot_ok(byte_addr))
                sfr_q[byte_addr[6:3]] <= byte_wdata;
            if (bit_we && bit_addr[7] && sfr_slot_ok(bit_target))
                sfr_q[bit_target[6:3]] <= bit_merged;
        end
    end

    // ram has no reset; a bit write in the same cycle as a byte write to that byte wins
    always @(posedge clk) begin
        if (byte_we && (byte_indirect || !byte_addr[7]) && byte_addr <= `BAAU_RAM_TOP)
            ram_q[byte_addr] <= byte_wdata;
        if (bit_we && !bit_addr[7])
            ram_q[bit_target] <= bit_merged;
    end

endmodule
`default_nettype wire

// ---- src/baau_consts.vh ----
// constants for the bit address and arithmetic unit
`ifndef BAAU_CONSTS_VH
`define BAAU_CONSTS_VH

// internal data space layout
`define BAAU_BITRAM_BASE    8'h20
`define BAAU_BITRAM_LAST    8'h2F
`define BAAU_RAM_TOP        8'hBF
`define BAAU_SFR_BASE       8'h80
`define BAAU_SFR_LAST       8'hF0

// bit addressable special function registers
`define BAAU_PORT_ZERO      8'h80
`define BAAU_TIMER_CONTROL  8'h88
`define BAAU_PORT_ONE       8'h90
`define BAAU_PORT_TWO       8'hA0
`define BAAU_IRQ_ENABLE     8'hA8
`define BAAU_PORT_THREE     8'hB0
`define BAAU_IRQ_PRIORITY   8'hB8
`define BAAU_SERIAL_STATUS  8'hC8
`define BAAU_PSW            8'hD0
`define BAAU_SERIAL_SEQ     8'hD8
`define BAAU_ACC            8'hE0
`define BAAU_MD_OPERAND     8'hF0

// reset value of every register held here
`define BAAU_REG_RESET      8'h00
`define BAAU_DATA_POINTER_RESET     16'h0000

// program status word flag positions
`define BAAU_PSW_CY         7
`define BAAU_PSW_AC         6
`define BAAU_PSW_OV         2
`define BAAU_PSW_P          0

// operation codes
`define BAAU_OP_ADD         4'h0
`define BAAU_OP_ADD_WITH_CARRY        4'h1
`define BAAU_OP_SUBTRACT_WITH_BORROW        4'h2
`define BAAU_OP_INC_A       4'h3
`define BAAU_OP_DEC_A       4'h4
`define BAAU_OP_INC_OPND    4'h5
`define BAAU_OP_DEC_OPND    4'h6
`define BAAU_OP_INC_DATA_POINTER    4'h7
`define BAAU_OP_MUL         4'h8
`define BAAU_OP_DIV         4'h9
`define BAAU_OP_DA          4'hA

// source operand forms
`define BAAU_FORM_REG       2'h0
`define BAAU_FORM_DIRECT    2'h1
`define BAAU_FORM_INDIRECT  2'h2
`define BAAU_FORM_IMM       2'h3

// machine cycle counts
`define BAAU_CYC_SHORT      3'h1
`define BAAU_CYC_DATA_POINTER       3'h2
`define BAAU_CYC_MULDIV     3'h4

`endif

// ---- tb/baau_core_props.sv ----
// assertion checker for the bit address and arithmetic unit
`timescale 1ns/100ps
`default_nettype none
module baau_props (
    input wire        clk,
    input wire        rst,
    input wire [7:0]  bit_addr,
    input wire        bit_we,
    input wire        bit_wdata,
    input wire        bit_rdata_q,
    input wire        byte_we,
    input wire        op_start,
    input wire [3:0]  op_code,
    input wire [1:0]  op_form,
    input wire [7:0]  op_operand,
    input wire        op_ready,
    input wire        op_done_q,
    input wire [1:0]  op_length,
    input wire [7:0]  op_result_q,
    input wire [7:0]  acc_out,
    input wire [7:0]  psw_out,
    input wire [15:0] data_pointer_out
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // a request only counts on an edge where the unit is free
    wire take = op_start && op_ready;

    ready_reset_a: assert property ($fell(rst) |-> op_ready && !op_done_q)
        else $error("unit busy after reset");
    short_op_a: assert property (take && (op_code < 4'h7 || op_code == 4'hA)
        |=> op_ready && op_done_q) else $error("single cycle operation late");
    long_op_a: assert property (take && op_code[3:1] == 3'h4
        |=> !op_ready [*3] ##1 (op_ready && op_done_q)) else $error("long operation timing");
    ptr_step_a: assert property (take && op_code == 4'h7 |=> !op_ready ##1
        (op_done_q && data_pointer_out == $past(data_pointer_out, 2) + 16'h0001))
        else $error("pointer increment wrong");
    add_sum_a: assert property (take && op_code < 4'h2 |=>
        {psw_out[7], acc_out} == {1'b0, $past(acc_out)} + $past(op_operand)
        + ($past(op_code) == 4'h1 && $past(psw_out[7])) && op_result_q == acc_out)
        else $error("add result wrong");
    sub_borrow_a: assert property (take && op_code == 4'h2 |=>
        {psw_out[7], acc_out} == {1'b0, $past(acc_out)} - $past(op_operand)
        - $past(psw_out[7])) else $error("subtract result wrong");
    form_len_a: assert property (op_length == (op_form[0] ? 2'h2 : 2'h1))
        else $error("instruction length wrong");
    bit_keep_a: assert property (bit_we && !byte_we && !op_start && op_ready ##1
        ($stable(bit_addr) && !bit_we && !byte_we && !op_start && op_ready)
        |=> bit_rdata_q == $past(bit_wdata, 2)) else $error("bit write lost");
endmodule
bind baau_core baau_props baau_props_i (.clk(clk), .rst(rst), .bit_addr(bit_addr),
    .bit_we(bit_we), .bit_wdata(bit_wdata), .bit_rdata_q(bit_rdata_q), .byte_we(byte_we),
    .op_start(op_start), .op_code(op_code), .op_form(op_form), .op_operand(op_operand),
    .op_ready(op_ready), .op_done_q(op_done_q), .op_length(op_length),
    .op_result_q(op_result_q), .acc_out(acc_out), .psw_out(psw_out),
    .data_pointer_out(data_pointer_out));
`default_nettype wire

// ---- tb/baau_core_bench.sv ----
// self-checking bench for the bit address and arithmetic unit
`timescale 1ns/100ps
`default_nettype none
module baau_core_bench;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  byte_addr = 8'h00;
    logic        byte_indirect = 1'b0;
    logic        byte_we = 1'b0;
    logic [7:0]  byte_wdata = 8'h00;
    logic [7:0]  bit_addr = 8'h00;
    logic        bit_we = 1'b0;
    logic        bit_wdata = 1'b0;
    logic        op_start = 1'b0;
    logic [3:0]  op_code = 4'h0;
    logic [1:0]  op_form = 2'h0;
    logic [7:0]  op_operand = 8'h00;
    wire  [7:0]  byte_rdata_q, op_result_q, acc_out, psw_out;
    wire         bit_rdata_q, op_ready, op_done_q;
    wire  [1:0]  op_length;
    wire  [15:0] data_pointer_out;
    logic [7:0]  pat = 8'h5A;
    logic [7:0]  sfr [12] = '{8'h80, 8'h88, 8'h90, 8'hA0, 8'hA8, 8'hB0, 8'hB8, 8'hC8,
                              8'hD0, 8'hD8, 8'hE0, 8'hF0};
    // code, form, operand, then carry and result expected after each step
    logic [31:0] tab [12] = '{32'h00C90103, 32'h11100014, 32'h222001F4, 32'h230300F0,
        32'h300000F1, 32'h400000F0, 32'h51FF0000, 32'h620000FF, 32'h03480138,
        32'hA0000198, 32'h000900A1, 32'hA0000107};
    int          fail_count = 0;
    int          comparisons = 0;

    always #2.5 clk = ~clk;

    baau_core baau_core_i (.clk(clk), .rst(rst), .byte_addr(byte_addr),
        .byte_indirect(byte_indirect), .byte_we(byte_we), .byte_wdata(byte_wdata),
        .byte_rdata_q(byte_rdata_q), .bit_addr(bit_addr), .bit_we(bit_we),
        .bit_wdata(bit_wdata), .bit_rdata_q(bit_rdata_q), .op_start(op_start),
        .op_code(op_code), .op_form(op_form), .op_operand(op_operand), .op_ready(op_ready),
        .op_done_q(op_done_q), .op_result_q(op_result_q), .op_length(op_length),
        .acc_out(acc_out), .psw_out(psw_out), .data_pointer_out(data_pointer_out));

    task automatic test_done;
        if (fail_count == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic step;
        @(posedge clk);
        #1;
    endtask
    // strobes stay high between writes so no driver lowers and raises them in one step
    task automatic wr_byte(input logic [7:0] a, input logic ind, input logic [7:0] d);
        {bit_we, byte_we, byte_indirect, byte_addr, byte_wdata} = {2'b01, ind, a, d};
        step();
    endtask
    task automatic rd_byte(input logic [7:0] a, input logic ind, input logic [7:0] e);
        {bit_we, byte_we, byte_indirect, byte_addr} = {2'b00, ind, a};
        step();
        cmp({8'h00, byte_rdata_q}, {8'h00, e});
    endtask
    task automatic wr_bit(input logic [7:0] a, input logic d);
        {byte_we, bit_we, bit_addr, bit_wdata} = {2'b01, a, d};
        step();
    endtask
    task automatic rd_bit(input logic [7:0] a, input logic e);
        {byte_we, bit_we, bit_addr} = {2'b00, a};
        step();
        cmp({15'h0000, bit_rdata_q}, {15'h0000, e});
    endtask
    task automatic run_op(input logic [3:0] c, input logic [1:0] f, input logic [7:0] d,
                          input int cyc);
        int n;
        n = 1;
        {byte_we, bit_we, op_start, op_code, op_form, op_operand} = {3'b001, c, f, d};
        step();
        op_start = 1'b0;
        while (op_done_q !== 1'b1 && n < 20) begin
            step();
            n++;
        end
        cmp(n[15:0], cyc[15:0]);
        step();
    endtask
    task automatic md_check(input logic [3:0] c, input logic [7:0] a, input logic [7:0] b,
                            input logic [15:0] e, input logic [7:0] eb);
        wr_byte(8'hE0, 1'b0, a);
        wr_byte(8'hF0, 1'b0, b);
        run_op(c, 2'h0, 8'h00, 4);
        cmp({psw_out[2], 7'h00, acc_out}, e);
        rd_byte(8'hF0, 1'b0, eb);
    endtask

    initial begin
        #20000;
        fail_count++;
        test_done();
    end

    initial begin
        repeat (6) @(posedge clk);
        #1;
        rst = 1'b0;
        cmp({acc_out, psw_out}, 16'h0000);
        wr_byte(8'h1F, 1'b1, 8'h77);
        wr_byte(8'h30, 1'b1, 8'hC3);
        wr_byte(8'h80, 1'b1, 8'h3C);
        for (int k = 0; k < 16; k++) begin
            wr_byte(8'h20 + k[7:0], 1'b1, pat);
            wr_bit({1'b0, k[3:0], k[2:0]}, ~pat[k[2:0]]);
            rd_bit({1'b0, k[3:0], k[2:0]}, ~pat[k[2:0]]);
            rd_byte(8'h20 + k[7:0], 1'b0, pat ^ (8'h01 << k[2:0]));
        end
        for (int i = 0; i < 12; i++) begin
            wr_byte(sfr[i], 1'b0, 8'h00);
            wr_bit(sfr[i] + 8'h03, 1'b1);
            rd_bit(sfr[i] + 8'h03, 1'b1);
            rd_bit(sfr[i] + 8'h02, 1'b0);
            rd_byte(sfr[i], 1'b0, 8'h08);
        end
        wr_bit(8'h80, 1'b1);
        rd_byte(8'h80, 1'b1, 8'h3C);
        rd_byte(8'h80, 1'b0, 8'h09);
        rd_byte(8'h1F, 1'b1, 8'h77);
        rd_byte(8'h30, 1'b1, 8'hC3);
        for (int f = 0; f < 4; f++) begin
            op_form = f[1:0];
            step();
            cmp({14'h0000, op_length}, {14'h0000, f[0] ? 2'h2 : 2'h1});
        end
        wr_byte(8'hE0, 1'b0, 8'h3A);
        for (int i = 0; i < 12; i++) begin
            run_op(tab[i][31:28], tab[i][25:24], tab[i][23:16], 1);
            cmp({7'h00, psw_out[7], op_result_q}, tab[i][15:0]);
        end
        cmp({8'h00, psw_out}, 16'h00C9);
        md_check(4'h8, 8'h50, 8'hA0, 16'h8000, 8'h32);
        md_check(4'h9, 8'hFB, 8'h12, 16'h000D, 8'h11);
        md_check(4'h9, 8'hFB, 8'h00, 16'h80FB, 8'h00);
        run_op(4'h7, 2'h0, 8'h00, 2);
        run_op(4'h7, 2'h0, 8'h00, 2);
        cmp(data_pointer_out, 16'h0002);
        test_done();
    end
endmodule
`default_nettype wire
